// ---- bench/rcas_host_bfm.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcas_host_bfm (
  input wire logic clk_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  logic [31:0] rdata;
  logic err;

  // bus idle at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
    rdata = 32'h0;
    err = 1'b0;
  end

  // one framed transfer: setup, access held until ready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    rdata = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released lines no longer show the old value
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask

  // two-step unlock, one status word per transfer
  task automatic unlock;
    xfer(1'b1, 12'h000, 32'h02);
    xfer(1'b1, 12'h000, 32'h06);
  endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic osc = 1'b0;
  logic start = 1'b0;
  logic m0 = 1'b0;
  logic m1 = 1'b0;
  logic sup_ok = 1'b1;
  logic bbat = 1'b0;
  logic abat = 1'b0;
  logic btrip = 1'b0;
  logic atrip = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rst_out_n, pin_n, on_bat, bus_off;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] div = 8'h0;
  int errors = 0;
  int checked = 0;
  int lows = 0;
  int tcnt = 0;
  int seed, n, r, k;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // oscillator stand-in, one tick every 8 clocks
  always @(posedge mclk) begin
    div <= div + 8'h1;
    osc <= div[2];
  end

  // low-cycle counter on the shared pin, and hang guard
  always @(posedge mclk) begin
    if (pin_n === 1'b0) lows <= lows + 1;
    tcnt <= tcnt + 1;
    if (tcnt == 30000) begin
      errors++;
      close_out();
    end
  end

  rcas_host_bfm host_u (
    .clk_i(mclk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr)
  );

  rcas_supervisor #(.POR_TICKS(8), .WD_MID_TICKS(24), .WD_LONG_TICKS(56), .NV_TICKS(6)) dut_u (
    .MCLK_I(mclk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .OSC_CLK_I(osc), .BUS_START_I(start),
    .ALARM0_MATCH_I(m0), .ALARM1_MATCH_I(m1), .SUPPLY_OK_I(sup_ok),
    .BELOW_BAT_I(bbat), .ABOVE_BAT_I(abat), .BELOW_TRIP_I(btrip),
    .ABOVE_TRIP_I(atrip), .RESET_N_O(rst_out_n), .IRQ_OR_CLOCK_OUT_PIN_N_O(pin_n),
    .ON_BATTERY_O(on_bat), .BUS_OFF_O(bus_off)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    host_u.xfer(1'b0, a, 32'h0);
  endtask

  // one-cycle event: 0 alarm 0, 1 alarm 1, 2 bus start
  task automatic pulse(input int w);
    @(posedge mclk);
    m0 <= (w == 0);
    m1 <= (w == 1);
    start <= (w == 2);
    @(posedge mclk);
    m0 <= 1'b0;
    m1 <= 1'b0;
    start <= 1'b0;
  endtask

  // full unlock, control write, then wait out the programming cycle
  task automatic set_ctrl(input logic [31:0] v);
    int i;
    host_u.unlock();
    wr(12'h004, v);
    chk("ctrl write err", {31'h0, host_u.err}, 32'h0);
    rd(12'h000);
    chk("busy and unlock", host_u.rdata & 32'h5, 32'h1);
    for (i = 0; i < 40 && host_u.rdata[0] !== 1'b0; i++) rd(12'h000);
    chk("busy ends", {31'h0, host_u.rdata[0]}, 32'h0);
  endtask

  initial begin
    seed = 83365;
    cyc(5);
    rst_n <= 1'b1;
    // power-on reset release after the supply-good time
    cyc(1);
    chk("reset held", {31'h0, rst_out_n}, 32'h0);
    for (n = 1; n < 200 && rst_out_n !== 1'b1; n++) cyc(1);
    chk("reset time", {31'h0, (n >= 56 && n < 100)}, 32'h1);
    rd(12'h004);
    chk("ctrl reset", host_u.rdata, 32'h20);
    set_ctrl(32'h1a0);
    $display("done: reset");
    // unlock sequence, refusals and clearing
    wr(12'h004, 32'h1a0);
    chk("locked write", {31'h0, host_u.err}, 32'h1);
    wr(12'h000, 32'h02);
    rd(12'h000);
    chk("wel set", host_u.rdata & 32'h6, 32'h2);
    wr(12'h000, 32'h06);
    rd(12'h004);
    rd(12'h000);
    chk("unlock set", host_u.rdata & 32'h6, 32'h6);
    wr(12'h008, 32'h1);
    chk("abort err", {31'h0, host_u.err}, 32'h1);
    rd(12'h000);
    chk("unlock kept", host_u.rdata & 32'h4, 32'h4);
    wr(12'h000, 32'h00);
    rd(12'h000);
    chk("latches clear", host_u.rdata & 32'h6, 32'h0);
    $display("done: unlock");
    // flags set without enables, cleared by a status read
    pulse(0);
    rd(12'h000);
    chk("flag set", host_u.rdata & 32'h60, 32'h20);
    rd(12'h000);
    chk("flag clear", host_u.rdata & 32'h60, 32'h0);
    // single-event mode, both alarms armed, random order
    set_ctrl(32'h1a3);
    for (k = 0; k < 4; k++) begin
      r = $random(seed) & 1;
      pulse(r);
      cyc(3 + ($random(seed) & 7));
      chk("pin low", {31'h0, pin_n}, 32'h0);
      rd(12'h000);
      chk("which flag", host_u.rdata & 32'h60, 32'h20 << r);
      cyc(2);
      chk("pin freed", {31'h0, pin_n}, 32'h1);
    end
    $display("done: single event");
    // pulsed mode, alarm 0 overrides alarm 1
    set_ctrl(32'h1a7);
    lows = 0;
    pulse(1);
    cyc(30);
    chk("alarm1 silent", lows, 32'h0);
    for (k = 0; k < 3; k++) begin
      lows = 0;
      pulse(0);
      cyc(40);
      chk("pulse width", {31'h0, (lows >= 9 && lows <= 18)}, 32'h1);
    end
    $display("done: pulsed");
    // clock out replaces the alarm function
    set_ctrl(32'h1a8);
    lows = 0;
    cyc(64);
    chk("clock out", {31'h0, (lows >= 31 && lows <= 33)}, 32'h1);
    $display("done: clock out");
    // legacy switchover with bus off in battery
    set_ctrl(32'h1e0);
    bbat <= 1'b1;
    cyc(3);
    chk("legacy to bat", {30'h0, on_bat, bus_off}, 32'h3);
    bbat <= 1'b0;
    abat <= 1'b1;
    cyc(3);
    chk("legacy back", {31'h0, on_bat}, 32'h0);
    abat <= 1'b0;
    // standard switchover needs both conditions down, either up
    set_ctrl(32'h180);
    bbat <= 1'b1;
    cyc(3);
    chk("std one cond", {31'h0, on_bat}, 32'h0);
    btrip <= 1'b1;
    cyc(3);
    chk("std to bat", {31'h0, on_bat}, 32'h1);
    bbat <= 1'b0;
    btrip <= 1'b0;
    cyc(3);
    chk("std hold", {31'h0, on_bat}, 32'h1);
    atrip <= 1'b1;
    cyc(3);
    chk("std back", {31'h0, on_bat}, 32'h0);
    atrip <= 1'b0;
    $display("done: switchover");
    // watchdog kept alive by starts, then left to expire
    set_ctrl(32'h0a0);
    for (k = 0; k < 6; k++) begin
      pulse(2);
      cyc(150);
      chk("wd alive", {31'h0, rst_out_n}, 32'h1);
    end
    pulse(2);
    for (n = 0; n < 400 && rst_out_n === 1'b1; n++) cyc(1);
    chk("wd period", {31'h0, (n >= 184 && n <= 202)}, 32'h1);
    cyc(20);
    pulse(2);
    for (n = 22; n < 400 && rst_out_n !== 1'b1; n++) cyc(1);
    chk("wd reset len", {31'h0, (n >= 56 && n <= 73)}, 32'h1);
    $display("done: watchdog");
    close_out();
  end
endmodule
`default_nettype wire

// ---- logic/rcas_map.svh ----
`ifndef RCAS_MAP_SVH
`define RCAS_MAP_SVH
// register byte offsets
`define RCAS_OFS_STATUS 12'h000
`define RCAS_OFS_CTRL 12'h004
// status register fields
`define RCAS_ST_BUSY 0
`define RCAS_ST_WEL 1
`define RCAS_ST_REGISTER_WRITE_UNLOCK 2
`define RCAS_ST_BATT 4
`define RCAS_ST_AL0 5
`define RCAS_ST_AL1 6
// status write codes
`define RCAS_CODE_WEL 8'h02
`define RCAS_CODE_REGISTER_WRITE_UNLOCK 8'h06
`define RCAS_CODE_CLR 8'h00
// control register width and reset value
`define RCAS_CTRL_W 9
`define RCAS_CTRL_RST 9'h020
// oscillator and times
`define RCAS_OSC_HZ 32768
`define RCAS_POR_MS 250
`define RCAS_WD_MID_MS 750
`define RCAS_WD_LONG_MS 1750
`define RCAS_NV_MS 20
`define RCAS_POR_TICKS ((`RCAS_POR_MS * `RCAS_OSC_HZ) / 1000)
`define RCAS_WD_MID_TICKS ((`RCAS_WD_MID_MS * `RCAS_OSC_HZ) / 1000)
`define RCAS_WD_LONG_TICKS ((`RCAS_WD_LONG_MS * `RCAS_OSC_HZ) / 1000)
`define RCAS_NV_TICKS ((`RCAS_NV_MS * `RCAS_OSC_HZ) / 1000)
`define RCAS_PULSE_TICKS 2
// clock-out divider taps
`define RCAS_TAP_4K 2
`define RCAS_TAP_1HZ 14
`define RCAS_DIV_W 15
`endif

// ---- logic/rcas_pkg.sv ----
package rcas_pkg;
  // reset supervisor states, gray along por -> run -> watchdog reset
  typedef enum logic [1:0] {
    SUP_POR = 2'b00,
    SUP_RUN = 2'b01,
    SUP_WDR = 2'b11
  } rcas_sup_e;

  // clock-out select encodings
  typedef enum logic [1:0] {
    FO_ALARM = 2'b00,
    FO_32K = 2'b01,
    FO_4K = 2'b10,
    FO_1HZ = 2'b11
  } rcas_fo_e;

  // watchdog period encodings
  typedef enum logic [1:0] {
    WD_LONG = 2'b00,
    WD_MID = 2'b01,
    WD_SHORT = 2'b10,
    WD_OFF = 2'b11
  } rcas_wd_e;

  // control register layout, msb first
  typedef struct packed {
    rcas_wd_e watchdog_period;
    logic bus_off_in_battery;
    logic supply_switch_policy;
    rcas_fo_e clock_out_select;
    logic pulsed_irq_select;
    logic alarm1_enable;
    logic alarm0_enable;
  } rcas_ctrl_s;

  // analog comparator results
  typedef struct packed {
    logic below_bat;
    logic above_bat;
    logic below_trip;
    logic above_trip;
  } rcas_cmp_s;
endpackage

// ---- logic/rcas_supervisor.sv ----
// How it works
// - host writes 02h to set write enable
// - then 06h sets unlock and write enable
// - control write starts 20ms programming cycle
// - completed control write clears unlock latch
// - aborted write keeps unlock latch set
// - writing zero clears both latches
// - reads leave unlock state untouched
// - match sets alarm flag regardless of enable
// - status read clears both alarm flags
// - single-event mode holds interrupt low
// - either armed alarm drives shared output
// - pulsed mode pulses at every match of alarm 0 if armed, else of armed alarm 1
// - pulsed mode alarm 0 overrides alarm 1
// - pulsing stops only via select or enables
// - standard mode needs both low conditions
// - standard mode returns on either condition
// - legacy mode runs from higher supply
// - reset held until supply good 250ms
// - watchdog period field selects timeout
// - start restarts watchdog, ignored during reset
// - watchdog expiry asserts reset for the 250ms reset time
// - clock-out select nonzero overrides alarm pin
`include "rcas_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rcas_supervisor #(
  parameter int POR_TICKS = `RCAS_POR_TICKS,
  parameter int WD_MID_TICKS = `RCAS_WD_MID_TICKS,
  parameter int WD_LONG_TICKS = `RCAS_WD_LONG_TICKS,
  parameter int NV_TICKS = `RCAS_NV_TICKS
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic OSC_CLK_I,
  input wire logic BUS_START_I,
  input wire logic ALARM0_MATCH_I,
  input wire logic ALARM1_MATCH_I,
  input wire logic SUPPLY_OK_I,
  input wire logic BELOW_BAT_I,
  input wire logic ABOVE_BAT_I,
  input wire logic BELOW_TRIP_I,
  input wire logic ABOVE_TRIP_I,
  output logic RESET_N_O,
  output logic IRQ_OR_CLOCK_OUT_PIN_N_O,
  output logic ON_BATTERY_O,
  output logic BUS_OFF_O
);
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic wel_ff;
  logic register_write_unlock_ff;
  logic alarm0_flag_ff;
  logic alarm1_flag_ff;
  rcas_pkg::rcas_ctrl_s ctrl_ff;
  logic nv_busy_ff;
  logic [15:0] nv_cnt_ff;
  logic osc_d_ff;
  logic [`RCAS_DIV_W-1:0] div_ff;
  rcas_pkg::rcas_sup_e sup_ff;
  rcas_pkg::rcas_sup_e nxt_sup;
  logic [15:0] tick_cnt_ff;
  logic [15:0] nxt_tick_cnt;
  logic [1:0] pulse_cnt_ff;
  logic on_battery_ff;
  logic reset_n_ff;
  logic pin_n_ff;
  logic bus_off_ff;
  rcas_pkg::rcas_cmp_s cmp;
  logic osc_tick;
  logic acc_phase;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic hit_status;
  logic hit_ctrl;
  logic ctrl_ok;
  logic [7:0] wbyte;
  logic [15:0] wd_limit;
  logic alarm_out_en;
  logic pulsed_mode;
  logic pulse_trig;
  logic irq_active;
  logic fout_lvl;
  logic [31:0] rd_word;

  // bus phase decode
  assign acc_phase = PSEL_I & PENABLE_I;
  assign acc_done = acc_phase & pready_ff;
  assign wr_done = acc_done & PWRITE_I;
  assign rd_done = acc_done & ~PWRITE_I;
  assign wbyte = PWDATA_I[7:0];
  assign cmp = {BELOW_BAT_I, ABOVE_BAT_I, BELOW_TRIP_I, ABOVE_TRIP_I};

  // address decode
  always_comb begin
    hit_status = 1'b0;
    hit_ctrl = 1'b0;
    if (PADDR_I == `RCAS_OFS_STATUS) begin
      hit_status = 1'b1;
    end else if (PADDR_I == `RCAS_OFS_CTRL) begin
      hit_ctrl = 1'b1;
    end
  end

  // control write needs the unlock latch and an idle programming cycle
  assign ctrl_ok = hit_ctrl & register_write_unlock_ff & ~nv_busy_ff;

  // read data mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_status) begin
      rd_word[`RCAS_ST_BUSY] = nv_busy_ff;
      rd_word[`RCAS_ST_WEL] = wel_ff;
      rd_word[`RCAS_ST_REGISTER_WRITE_UNLOCK] = register_write_unlock_ff;
      rd_word[`RCAS_ST_BATT] = on_battery_ff;
      rd_word[`RCAS_ST_AL0] = alarm0_flag_ff;
      rd_word[`RCAS_ST_AL1] = alarm1_flag_ff;
    end else if (hit_ctrl) begin
      rd_word[`RCAS_CTRL_W-1:0] = ctrl_ff;
    end
  end

  // one wait state, answer registered
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= acc_phase & ~pready_ff;
      if (acc_phase & ~pready_ff) begin
        prdata_ff <= PWRITE_I ? 32'h0000_0000 : rd_word;
        pslverr_ff <= ~(hit_status | hit_ctrl) | (PWRITE_I & hit_ctrl & ~ctrl_ok);
      end
    end
  end

  // write enable and unlock latches
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wel_ff <= 1'b0;
      register_write_unlock_ff <= 1'b0;
    end else if (wr_done & hit_status) begin
      if (wbyte == `RCAS_CODE_WEL) begin
        wel_ff <= 1'b1;
      end else if (wbyte == `RCAS_CODE_REGISTER_WRITE_UNLOCK && wel_ff) begin
        wel_ff <= 1'b1;
        register_write_unlock_ff <= 1'b1;
      end else if (wbyte == `RCAS_CODE_CLR) begin
        wel_ff <= 1'b0;
        register_write_unlock_ff <= 1'b0;
      end
    end else if (wr_done & ctrl_ok) begin
      register_write_unlock_ff <= 1'b0;
    end
    // refused writes and any read leave both latches alone
  end

  // control register, written only when unlocked
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_ff <= `RCAS_CTRL_RST;
    end else if (wr_done & ctrl_ok) begin
      ctrl_ff <= PWDATA_I[`RCAS_CTRL_W-1:0];
    end
  end

  // programming cycle after a control write
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nv_busy_ff <= 1'b0;
      nv_cnt_ff <= 16'h0000;
    end else if (wr_done & ctrl_ok) begin
      nv_busy_ff <= 1'b1;
      nv_cnt_ff <= 16'h0000;
    end else if (nv_busy_ff && osc_tick) begin
      if (nv_cnt_ff == 16'(NV_TICKS - 1)) begin
        nv_busy_ff <= 1'b0;
      end
      nv_cnt_ff <= nv_cnt_ff + 16'h0001;
    end
  end

  // alarm flags, a match in the clearing cycle wins
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      alarm0_flag_ff <= 1'b0;
      alarm1_flag_ff <= 1'b0;
    end else begin
      if (ALARM0_MATCH_I) begin
        alarm0_flag_ff <= 1'b1;
      end else if (rd_done & hit_status) begin
        alarm0_flag_ff <= 1'b0;
      end
      if (ALARM1_MATCH_I) begin
        alarm1_flag_ff <= 1'b1;
      end else if (rd_done & hit_status) begin
        alarm1_flag_ff <= 1'b0;
      end
    end
  end

  // oscillator edge and divider chain
  assign osc_tick = OSC_CLK_I & ~osc_d_ff;
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      osc_d_ff <= 1'b0;
      div_ff <= '0;
    end else begin
      osc_d_ff <= OSC_CLK_I;
      if (osc_tick) begin
        div_ff <= div_ff + `RCAS_DIV_W'(1);
      end
    end
  end

  // interrupt modes
  assign alarm_out_en = (ctrl_ff.clock_out_select == rcas_pkg::FO_ALARM);
  assign pulsed_mode = ctrl_ff.pulsed_irq_select
    & (ctrl_ff.alarm0_enable | ctrl_ff.alarm1_enable);
  assign pulse_trig = ctrl_ff.alarm0_enable ? ALARM0_MATCH_I
    : (ctrl_ff.alarm1_enable & ALARM1_MATCH_I);

  // pulse stretcher for pulsed mode
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pulse_cnt_ff <= 2'h0;
    end else if (!pulsed_mode) begin
      pulse_cnt_ff <= 2'h0;
    end else if (pulse_trig) begin
      pulse_cnt_ff <= 2'(`RCAS_PULSE_TICKS);
    end else if (osc_tick && pulse_cnt_ff != 2'h0) begin
      pulse_cnt_ff <= pulse_cnt_ff - 2'h1;
    end
  end

  // single event holds while a flag of an armed alarm stands
  always_comb begin
    if (pulsed_mode) begin
      irq_active = (pulse_cnt_ff != 2'h0);
    end else begin
      irq_active = (ctrl_ff.alarm0_enable & alarm0_flag_ff)
        | (ctrl_ff.alarm1_enable & alarm1_flag_ff);
    end
  end

  // clock-out tap select
  always_comb begin
    case (ctrl_ff.clock_out_select)
      rcas_pkg::FO_32K: fout_lvl = OSC_CLK_I;
      rcas_pkg::FO_4K: fout_lvl = div_ff[`RCAS_TAP_4K];
      rcas_pkg::FO_1HZ: fout_lvl = div_ff[`RCAS_TAP_1HZ];
      default: fout_lvl = 1'b1;
    endcase
  end

  // shared pin register
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_n_ff <= 1'b1;
    end else begin
      pin_n_ff <= alarm_out_en ? ~irq_active : fout_lvl;
    end
  end

  // supply switchover
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      on_battery_ff <= 1'b0;
    end else if (ctrl_ff.supply_switch_policy) begin
      if (!on_battery_ff && cmp.below_bat) begin
        on_battery_ff <= 1'b1;
      end else if (on_battery_ff && cmp.above_bat) begin
        on_battery_ff <= 1'b0;
      end
    end else begin
      if (!on_battery_ff && cmp.below_bat && cmp.below_trip) begin
        on_battery_ff <= 1'b1;
      end else if (on_battery_ff && (cmp.above_bat || cmp.above_trip)) begin
        on_battery_ff <= 1'b0;
      end
    end
  end

  // bus shutdown flag while on battery
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bus_off_ff <= 1'b0;
    end else begin
      bus_off_ff <= ctrl_ff.bus_off_in_battery & on_battery_ff;
    end
  end

  // watchdog period lookup
  always_comb begin
    case (ctrl_ff.watchdog_period)
      rcas_pkg::WD_SHORT: wd_limit = 16'(POR_TICKS);
      rcas_pkg::WD_MID: wd_limit = 16'(WD_MID_TICKS);
      rcas_pkg::WD_LONG: wd_limit = 16'(WD_LONG_TICKS);
      default: wd_limit = 16'h0000;
    endcase
  end

  // reset supervisor next state
  always_comb begin
    nxt_sup = sup_ff;
    nxt_tick_cnt = tick_cnt_ff;
    case (sup_ff)
      rcas_pkg::SUP_POR: begin
        if (!SUPPLY_OK_I) begin
          nxt_tick_cnt = 16'h0000;
        end else if (osc_tick) begin
          if (tick_cnt_ff == 16'(POR_TICKS - 1)) begin
            nxt_sup = rcas_pkg::SUP_RUN;
            nxt_tick_cnt = 16'h0000;
          end else begin
            nxt_tick_cnt = tick_cnt_ff + 16'h0001;
          end
        end
      end
      rcas_pkg::SUP_RUN: begin
        if (!SUPPLY_OK_I) begin
          nxt_sup = rcas_pkg::SUP_POR;
          nxt_tick_cnt = 16'h0000;
        end else if (BUS_START_I || wd_limit == 16'h0000) begin
          nxt_tick_cnt = 16'h0000;
        end else if (osc_tick) begin
          if (tick_cnt_ff == wd_limit - 16'h0001) begin
            nxt_sup = rcas_pkg::SUP_WDR;
            nxt_tick_cnt = 16'h0000;
          end else begin
            nxt_tick_cnt = tick_cnt_ff + 16'h0001;
          end
        end
      end
      rcas_pkg::SUP_WDR: begin
        if (!SUPPLY_OK_I) begin
          nxt_sup = rcas_pkg::SUP_POR;
          nxt_tick_cnt = 16'h0000;
        end else if (osc_tick) begin
          if (tick_cnt_ff == 16'(POR_TICKS - 1)) begin
            nxt_sup = rcas_pkg::SUP_RUN;
            nxt_tick_cnt = 16'h0000;
          end else begin
            nxt_tick_cnt = tick_cnt_ff + 16'h0001;
          end
        end
      end
      default: begin
        nxt_sup = rcas_pkg::SUP_POR;
        nxt_tick_cnt = 16'h0000;
      end
    endcase
  end

  // reset supervisor state and output
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sup_ff <= rcas_pkg::SUP_POR;
      tick_cnt_ff <= 16'h0000;
      reset_n_ff <= 1'b0;
    end else begin
      sup_ff <= nxt_sup;
      tick_cnt_ff <= nxt_tick_cnt;
      reset_n_ff <= (nxt_sup == rcas_pkg::SUP_RUN);
    end
  end

  assign PRDATA_O = prdata_ff;
  assign PREADY_O = pready_ff;
  assign PSLVERR_O = pslverr_ff;
  assign RESET_N_O = reset_n_ff;
  assign IRQ_OR_CLOCK_OUT_PIN_N_O = pin_n_ff;
  assign ON_BATTERY_O = on_battery_ff;
  assign BUS_OFF_O = bus_off_ff;

  // checks
  sequence status_wr(logic [7:0] code);
    wr_done && hit_status && wbyte == code;
  endsequence

  sequence ctrl_accept;
    wr_done && ctrl_ok;
  endsequence

  wel_set_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    status_wr(`RCAS_CODE_WEL) |=> wel_ff)
    else $error("write enable not set by 02h");
  unlock_set_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (status_wr(`RCAS_CODE_REGISTER_WRITE_UNLOCK) and wel_ff) |=> (register_write_unlock_ff && wel_ff))
    else $error("unlock not set by 06h");
  nv_cycle_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    ctrl_accept |=> nv_busy_ff [*8])
    else $error("programming cycle not started");
  unlock_clear_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    ctrl_accept |=> !register_write_unlock_ff && ctrl_ff == $past(PWDATA_I[`RCAS_CTRL_W-1:0]))
    else $error("unlock kept after control write");
  refused_keeps_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (wr_done && hit_ctrl && register_write_unlock_ff && nv_busy_ff) |=> register_write_unlock_ff && $stable(ctrl_ff))
    else $error("refused write changed state");
  zero_clear_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    status_wr(`RCAS_CODE_CLR) |=> !wel_ff && !register_write_unlock_ff)
    else $error("zero write did not clear latches");
  read_keeps_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    rd_done |=> $stable(wel_ff) && $stable(register_write_unlock_ff))
    else $error("read disturbed unlock state");
  alarm_set_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    ALARM0_MATCH_I |=> alarm0_flag_ff)
    else $error("alarm 0 flag not set");
  flag_clear_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (rd_done && hit_status && !ALARM0_MATCH_I && !ALARM1_MATCH_I)
    |=> !alarm0_flag_ff && !alarm1_flag_ff)
    else $error("status read did not clear flags");
  single_low_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (alarm_out_en && !pulsed_mode && ctrl_ff.alarm0_enable && alarm0_flag_ff)
    |=> !pin_n_ff)
    else $error("single event output not low");
  legacy_up_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (ctrl_ff.supply_switch_policy && !on_battery_ff && cmp.below_bat) |=> on_battery_ff)
    else $error("legacy switch to battery missed");
  start_ignored_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (sup_ff == rcas_pkg::SUP_WDR && BUS_START_I && SUPPLY_OK_I && !osc_tick)
    |=> $stable(tick_cnt_ff) && !reset_n_ff)
    else $error("start disturbed watchdog reset");
endmodule
`default_nettype wire
